// file: core/flash_area_host.sv
// Purpose: Host that issues code/data flash sequencer commands
// Assumes: Device registers reached by index on DEV_SEL/DEV_WDATA/DEV_WR
// Notes:   Software orders arrive over classic Wishbone
// How it works
// - Verify range derived from block, both pairs
// - Erase range derived from block, both pairs
// - Code block uses ten low bits
// - Data block uses six low bits
// - Verify block must be zero to 511
// - Erase block must be zero to 63
// - Verify once, only right after writing
// - Erase only with data access enabled
// - No command while either sequencer busy
// - Verify only in code programming mode
// - Erase only in data programming mode
`timescale 1ns/100ps
`include "flash_seq_regs.svh"
module flash_area_host #(
	parameter int          CF_BLOCKS  = 512,
	parameter int          DF_BLOCKS  = 64,
	parameter logic [23:0] DF_BASE    = 24'h10_0000,
	parameter int          START_WAIT = `FS_START_WAIT
) (
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	input  wire logic        WB_WE_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	output logic             WB_ACK_O,
	output logic             IRQ,
	output logic      [3:0]  DEV_SEL,
	output logic      [15:0] DEV_WDATA,
	output logic             DEV_WR,
	input  wire logic        DEV_CF_BUSY,
	input  wire logic        DEV_EX_BUSY,
	input  wire logic        DEV_CODE_MODE,
	input  wire logic        DEV_DATA_MODE,
	input  wire logic        DEV_ACCESS_ON
);
	flash_seq_pkg::state_t state_ff;
	flash_seq_pkg::op_t    op_ff;
	flash_seq_pkg::op_t    run_op_ff;
	logic [9:0]                 block_ff;
	logic [23:0]                paddr_ff;
	logic [31:0]                pdata_ff;
	logic [`FS_IRQ_W-1:0]       irq_stat_ff;
	logic [`FS_IRQ_W-1:0]       irq_mask_ff;
	logic                       ack_ff;
	logic [31:0]                dat_ff;
	logic [23:0]                sa_ff;
	logic [23:0]                ea_ff;
	logic [2:0]                 step_ff;
	logic [15:0]                wait_ff;
	logic                       verify_ok_ff;
	logic [9:0]                 last_blk_ff;
	logic [3:0]                 dev_sel_ff;
	logic [15:0]                dev_wdata_ff;
	logic                       dev_wr_ff;
	logic [4:0]                 pins_s;
	logic                       cf_busy_s;
	logic                       ex_busy_s;
	logic                       code_mode_s;
	logic                       data_mode_s;
	logic                       access_on_s;
	logic                       wr_en;
	logic [31:0]                wmask;
	logic [31:0]                rd_mux;
	logic                       go_req;
	logic                       idle;
	logic                       accept;
	logic                       refuse;
	logic                       done_evt;
	logic                       is_data_op;
	logic [23:0]                calc_sa;
	logic [23:0]                calc_ea;
	logic [7:0]                 cmd_byte;
	logic [`FS_IRQ_W-1:0]       irq_set;
	logic [31:0]                ctrl_new;

	initial begin
		if (CF_BLOCKS < 1 || CF_BLOCKS > 512 || DF_BLOCKS < 1 ||
		    DF_BLOCKS > 64 || START_WAIT < 2 || START_WAIT > 65535)
			$error("flash_area_host parameters out of range");
	end

	// Device status pins come from another clock domain
	sync_pair #(.W(5)) u_sync (
		.MCLK(MCLK),
		.RST (RST),
		.CE  (CE),
		.D   ({DEV_ACCESS_ON, DEV_DATA_MODE, DEV_CODE_MODE,
		        DEV_EX_BUSY, DEV_CF_BUSY}),
		.Q   (pins_s)
	);
	assign cf_busy_s   = pins_s[0];
	assign ex_busy_s   = pins_s[1];
	assign code_mode_s = pins_s[2];
	assign data_mode_s = pins_s[3];
	assign access_on_s = pins_s[4];

	assign is_data_op = (op_ff == flash_seq_pkg::OP_ERASE);

	block_range #(.DF_BASE(DF_BASE)) u_range (
		.is_data   (is_data_op),
		.block     (block_ff),
		.start_addr(calc_sa),
		.end_addr  (calc_ea)
	);

	// Bus write lands at the edge where the master sees ack
	assign wr_en = ack_ff && WB_CYC_I && WB_STB_I && WB_WE_I;
	assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
	                {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
	assign ctrl_new = (WB_DAT_I & wmask) |
	                  ({24'h00_0000, 5'h00, op_ff} & ~wmask);
	assign go_req = wr_en && (WB_ADR_I == `FS_OFS_CTRL) &&
	                WB_SEL_I[0] && WB_DAT_I[`FS_CTRL_GO_BIT];
	assign idle   = (state_ff == flash_seq_pkg::ST_IDLE);

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (WB_ADR_I)
			`FS_OFS_CTRL:     rd_mux[2:0] = op_ff;
			`FS_OFS_BLOCK:    rd_mux[9:0] = block_ff;
			`FS_OFS_PADDR:    rd_mux[23:0] = paddr_ff;
			`FS_OFS_PDATA:    rd_mux = pdata_ff;
			`FS_OFS_STATUS: begin
				rd_mux[`FS_ST_RUNNING]   = !idle;
				rd_mux[`FS_ST_VERIFY_OK] = verify_ok_ff;
				rd_mux[`FS_ST_CF_BUSY]   = cf_busy_s;
				rd_mux[`FS_ST_EX_BUSY]   = ex_busy_s;
				rd_mux[`FS_ST_CODE_MODE] = code_mode_s;
				rd_mux[`FS_ST_DATA_MODE] = data_mode_s;
				rd_mux[`FS_ST_ACCESS_ON] = access_on_s;
			end
			`FS_OFS_IRQ_STAT: rd_mux[`FS_IRQ_W-1:0] = irq_stat_ff;
			`FS_OFS_IRQ_MASK: rd_mux[`FS_IRQ_W-1:0] = irq_mask_ff;
			default:          rd_mux = 32'h0000_0000;
		endcase
	end

	// Slave answers one cycle after the request, unmapped reads zero
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else if (CE) begin
			ack_ff <= WB_CYC_I && WB_STB_I && !ack_ff;
			if (WB_CYC_I && WB_STB_I && !ack_ff)
				dat_ff <= rd_mux;
		end
	end

	// Command setup registers are frozen while a command runs
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			op_ff    <= flash_seq_pkg::op_t'(`FS_RST_OP);
			block_ff <= `FS_RST_BLOCK;
			paddr_ff <= `FS_RST_PADDR;
			pdata_ff <= `FS_RST_PDATA;
		end else if (CE && wr_en && idle) begin
			case (WB_ADR_I)
				`FS_OFS_CTRL:
					op_ff <= flash_seq_pkg::op_t'(ctrl_new[2:0]);
				`FS_OFS_BLOCK:
					block_ff <= WB_DAT_I[9:0] & wmask[9:0];
				`FS_OFS_PADDR:
					paddr_ff <= (WB_DAT_I[23:0] & wmask[23:0]) |
					            (paddr_ff & ~wmask[23:0]);
				`FS_OFS_PDATA:
					pdata_ff <= (WB_DAT_I & wmask) | (pdata_ff & ~wmask);
				default: ;
			endcase
		end
	end

	// Precondition check on the synchronised device state
	always_comb begin
		accept = 1'b0;
		if (!cf_busy_s && !ex_busy_s) begin
			case (op_ff)
				flash_seq_pkg::OP_WRITE:
					accept = code_mode_s || (data_mode_s && access_on_s);
				flash_seq_pkg::OP_VERIFY:
					accept = code_mode_s &&
					         block_ff <= `FS_CF_BLK_MAX &&
					         32'(block_ff) < CF_BLOCKS &&
					         verify_ok_ff && block_ff == last_blk_ff;
				flash_seq_pkg::OP_BLANK:
					accept = code_mode_s && 32'(block_ff) < CF_BLOCKS;
				flash_seq_pkg::OP_ERASE:
					accept = data_mode_s && access_on_s &&
					         block_ff[9:6] == 4'h0 &&
					         32'(block_ff[5:0]) < DF_BLOCKS;
				default:
					accept = 1'b0;
			endcase
		end
	end

	assign refuse = (go_req && !idle) ||
	                (state_ff == flash_seq_pkg::ST_CHECK && !accept);
	assign done_evt = (state_ff == flash_seq_pkg::ST_WAIT_END &&
	                   !cf_busy_s) ||
	                  (state_ff == flash_seq_pkg::ST_WAIT_GO && !cf_busy_s &&
	                   32'(wait_ff) == START_WAIT - 1);

	// Command byte: go bit, mode change clear, op field
	assign cmd_byte = {1'b1, 4'h0, run_op_ff};

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			state_ff  <= flash_seq_pkg::ST_IDLE;
			run_op_ff <= flash_seq_pkg::OP_NONE;
			sa_ff     <= 24'h00_0000;
			ea_ff     <= 24'h00_0000;
			step_ff   <= 3'h0;
			wait_ff   <= 16'h0000;
		end else if (CE) begin
			case (state_ff)
				flash_seq_pkg::ST_IDLE: begin
					if (go_req)
						state_ff <= flash_seq_pkg::ST_CHECK;
				end
				flash_seq_pkg::ST_CHECK: begin
					run_op_ff <= op_ff;
					step_ff   <= 3'h0;
					sa_ff     <= (op_ff == flash_seq_pkg::OP_WRITE) ?
					             paddr_ff : calc_sa;
					ea_ff     <= calc_ea;
					state_ff  <= accept ? flash_seq_pkg::ST_LOAD :
					                      flash_seq_pkg::ST_IDLE;
				end
				flash_seq_pkg::ST_LOAD: begin
					step_ff <= step_ff + 3'h1;
					wait_ff <= 16'h0000;
					if (step_ff == `FS_LOAD_LAST)
						state_ff <= flash_seq_pkg::ST_WAIT_GO;
				end
				flash_seq_pkg::ST_WAIT_GO: begin
					// A fast device may finish before busy is ever seen
					wait_ff <= wait_ff + 16'h0001;
					if (cf_busy_s)
						state_ff <= flash_seq_pkg::ST_WAIT_END;
					else if (done_evt)
						state_ff <= flash_seq_pkg::ST_IDLE;
				end
				flash_seq_pkg::ST_WAIT_END: begin
					if (done_evt)
						state_ff <= flash_seq_pkg::ST_IDLE;
				end
				default: state_ff <= flash_seq_pkg::ST_IDLE;
			endcase
		end
	end

	// One device register write per load step
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			dev_sel_ff   <= `FS_DEV_AREA;
			dev_wdata_ff <= 16'h0000;
			dev_wr_ff    <= 1'b0;
		end else if (CE) begin
			dev_wr_ff <= (state_ff == flash_seq_pkg::ST_LOAD);
			case (step_ff)
				3'h0: begin
					dev_sel_ff   <= `FS_DEV_AREA;
					dev_wdata_ff <= `FS_AREA_USER;
				end
				3'h1: begin
					dev_sel_ff   <= `FS_DEV_SA_LO;
					dev_wdata_ff <= sa_ff[15:0];
				end
				3'h2: begin
					dev_sel_ff   <= `FS_DEV_SA_HI;
					dev_wdata_ff <= {8'h00, sa_ff[23:16]};
				end
				3'h3: begin
					// Program sends data in place of the end address
					if (run_op_ff == flash_seq_pkg::OP_WRITE) begin
						dev_sel_ff   <= `FS_DEV_WD_LO;
						dev_wdata_ff <= pdata_ff[15:0];
					end else begin
						dev_sel_ff   <= `FS_DEV_EA_LO;
						dev_wdata_ff <= ea_ff[15:0];
					end
				end
				3'h4: begin
					if (run_op_ff == flash_seq_pkg::OP_WRITE) begin
						dev_sel_ff   <= `FS_DEV_WD_HI;
						dev_wdata_ff <= pdata_ff[31:16];
					end else begin
						dev_sel_ff   <= `FS_DEV_EA_HI;
						dev_wdata_ff <= {8'h00, ea_ff[23:16]};
					end
				end
				default: begin
					dev_sel_ff   <= `FS_DEV_CMD;
					dev_wdata_ff <= {8'h00, cmd_byte};
				end
			endcase
		end
	end

	// Verify is allowed once, on the block most recently programmed
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			verify_ok_ff <= 1'b0;
			last_blk_ff  <= 10'h000;
		end else if (CE) begin
			if (done_evt && run_op_ff == flash_seq_pkg::OP_WRITE &&
			    sa_ff < DF_BASE) begin
				verify_ok_ff <= 1'b1;
				last_blk_ff  <= sa_ff[19:10];
			end else if (state_ff == flash_seq_pkg::ST_CHECK && accept &&
			             op_ff != flash_seq_pkg::OP_WRITE) begin
				verify_ok_ff <= 1'b0;
			end
		end
	end

	// Sticky events, set wins over a write-one clear
	assign irq_set = {refuse, done_evt};
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			irq_stat_ff <= `FS_RST_IRQ;
			irq_mask_ff <= `FS_RST_IRQ;
		end else if (CE) begin
			if (wr_en && WB_ADR_I == `FS_OFS_IRQ_STAT && WB_SEL_I[0])
				irq_stat_ff <= (irq_stat_ff & ~WB_DAT_I[`FS_IRQ_W-1:0]) |
				               irq_set;
			else
				irq_stat_ff <= irq_stat_ff | irq_set;
			if (wr_en && WB_ADR_I == `FS_OFS_IRQ_MASK && WB_SEL_I[0])
				irq_mask_ff <= WB_DAT_I[`FS_IRQ_W-1:0];
		end
	end

	assign WB_ACK_O  = ack_ff;
	assign WB_DAT_O  = dat_ff;
	assign IRQ       = |(irq_stat_ff & irq_mask_ff);
	assign DEV_SEL   = dev_sel_ff;
	assign DEV_WDATA = dev_wdata_ff;
	assign DEV_WR    = dev_wr_ff;
endmodule : flash_area_host

// file: core/flash_seq_regs.svh
// Purpose: Offsets, fields, reset values and counts for the flash host
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes:   Device register indices select the device's own port
`ifndef FLASH_SEQ_REGS_SVH
`define FLASH_SEQ_REGS_SVH

// Software register byte offsets
`define FS_OFS_CTRL       8'h00
`define FS_OFS_BLOCK      8'h04
`define FS_OFS_PADDR      8'h08
`define FS_OFS_PDATA      8'h0C
`define FS_OFS_STATUS     8'h10
`define FS_OFS_IRQ_STAT   8'h14
`define FS_OFS_IRQ_MASK   8'h18

// Control register fields
`define FS_CTRL_GO_BIT    7
`define FS_CTRL_OP_LSB    0
`define FS_CTRL_OP_W      3

// Status register fields
`define FS_ST_RUNNING     0
`define FS_ST_VERIFY_OK   1
`define FS_ST_CF_BUSY     2
`define FS_ST_EX_BUSY     3
`define FS_ST_CODE_MODE   4
`define FS_ST_DATA_MODE   5
`define FS_ST_ACCESS_ON   6

// Interrupt status and mask fields
`define FS_IRQ_DONE       0
`define FS_IRQ_REFUSED    1
`define FS_IRQ_W          2

// Reset values
`define FS_RST_OP         3'h0
`define FS_RST_BLOCK      10'h000
`define FS_RST_PADDR      24'h00_0000
`define FS_RST_PDATA      32'h0000_0000
`define FS_RST_IRQ        2'h0

// Device register indices on the device port
`define FS_DEV_AREA       4'h0
`define FS_DEV_SA_LO      4'h1
`define FS_DEV_SA_HI      4'h2
`define FS_DEV_EA_LO      4'h3
`define FS_DEV_EA_HI      4'h4
`define FS_DEV_WD_LO      4'h5
`define FS_DEV_WD_HI      4'h6
`define FS_DEV_CMD        4'h7

// Device register values and fields
`define FS_AREA_USER      16'h0000
`define FS_EXTRA_BIT      0
`define FS_GO_BIT         7
`define FS_MODE_CHG_BIT   3
`define FS_BLOCK_BYTES    24'h00_0400
`define FS_CF_BLK_W       10
`define FS_DF_BLK_W       6
`define FS_CF_BLK_MAX     10'h1FF
`define FS_DF_BLK_MAX     6'h3F

// Timing counts
`define FS_START_WAIT     64
`define FS_LOAD_LAST      3'h5

`endif

// file: core/flash_seq_pkg.sv
// Purpose: Types shared by the flash host modules
// Assumes: Constants live in flash_seq_regs.svh
// Notes:   One-hot state codes written out
package flash_seq_pkg;

	typedef enum logic [2:0] {
		OP_NONE   = 3'h0,
		OP_WRITE  = 3'h1,
		OP_VERIFY = 3'h2,
		OP_BLANK  = 3'h3,
		OP_ERASE  = 3'h4
	} op_t;

	typedef enum logic [4:0] {
		ST_IDLE     = 5'h01,
		ST_CHECK    = 5'h02,
		ST_LOAD     = 5'h04,
		ST_WAIT_GO  = 5'h08,
		ST_WAIT_END = 5'h10
	} state_t;

endpackage : flash_seq_pkg

// file: core/sync_pair.sv
// Purpose: Two-flop synchroniser for device status pins
// Assumes: Inputs are levels from outside the MCLK domain
// Notes:   First stage is read by the second stage only
`timescale 1ns/100ps
module sync_pair #(
	parameter int W = 1
) (
	input  wire logic         MCLK,
	input  wire logic         RST,
	input  wire logic         CE,
	input  wire logic [W-1:0] D,
	output logic      [W-1:0] Q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] hold_ff;

	initial begin
		if (W < 1)
			$error("sync_pair width must be at least one");
	end

	always_ff @(posedge MCLK or posedge RST) begin
		if (RST) begin
			meta_ff <= '0;
			hold_ff <= '0;
		end else if (CE) begin
			meta_ff <= D;
			hold_ff <= meta_ff;
		end
	end

	assign Q = hold_ff;
endmodule : sync_pair

// file: core/block_range.sv
// Purpose: Start and end address of one 1024-byte flash block
// Assumes: Code flash starts at zero, data flash at a base parameter
// Notes:   Block number bits above the used width are ignored
`timescale 1ns/100ps
`include "flash_seq_regs.svh"
module block_range #(
	parameter logic [23:0] DF_BASE = 24'h10_0000
) (
	input  wire logic        is_data,
	input  wire logic [9:0]  block,
	output logic      [23:0] start_addr,
	output logic      [23:0] end_addr
);
	logic [23:0] offset;

	always_comb begin
		if (is_data)
			offset = {8'h00, block[`FS_DF_BLK_W-1:0], 10'h000};
		else
			offset = {4'h0, block[`FS_CF_BLK_W-1:0], 10'h000};
		start_addr = is_data ? DF_BASE + offset : offset;
		end_addr   = start_addr + `FS_BLOCK_BYTES - 24'h00_0001;
	end
endmodule : block_range

// file: dv/flash_area_host_properties.sv
// Purpose: Port-level checks on the flash host
// Assumes: One clock, async active-high reset
// Notes:   Bound into every flash_area_host
`timescale 1ns/100ps
module flash_area_host_properties (
	input wire logic        MCLK,
	input wire logic        RST,
	input wire logic        WB_CYC_I,
	input wire logic        WB_STB_I,
	input wire logic        WB_ACK_O,
	input wire logic [3:0]  DEV_SEL,
	input wire logic [15:0] DEV_WDATA,
	input wire logic        DEV_WR,
	input wire logic        DEV_CF_BUSY,
	input wire logic        DEV_EX_BUSY
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);

	logic [9:0] busy_hist_ff;
	logic       cmd_wr;

	// Wide window so the two-flop sync delay cannot hide a busy pin
	always_ff @(posedge MCLK or posedge RST) begin
		if (RST)
			busy_hist_ff <= 10'h000;
		else
			busy_hist_ff <= {busy_hist_ff[8:0], DEV_CF_BUSY | DEV_EX_BUSY};
	end

	assign cmd_wr = DEV_WR && DEV_SEL == 4'h7;

	a_ack_after_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
		|=> WB_ACK_O) else $error("ack missing after request");
	a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	a_ack_has_req: assert property ($rose(WB_ACK_O) |-> $past(WB_STB_I))
		else $error("ack without strobe");
	a_area_load_order: assert property (DEV_WR && DEV_SEL == 4'h0
		|-> DEV_WDATA == 16'h0000 ##1 DEV_WR && DEV_SEL == 4'h1
		##1 DEV_WR && DEV_SEL == 4'h2
		##1 DEV_WR && DEV_SEL inside {4'h3, 4'h5}
		##1 DEV_WR && DEV_SEL inside {4'h4, 4'h6} ##1 cmd_wr)
		else $error("device load order broken");
	a_cmd_after_area: assert property (cmd_wr |-> $past(DEV_WR, 5)
		&& $past(DEV_SEL, 5) == 4'h0) else $error("command without area");
	a_cmd_byte_form: assert property (cmd_wr
		|-> DEV_WDATA[15:3] == 13'h0010 && DEV_WDATA[2:0] inside
		{3'h1, 3'h2, 3'h3, 3'h4}) else $error("bad command byte");
	a_hi_byte_zero: assert property (DEV_WR && DEV_SEL inside {4'h2, 4'h4}
		|-> DEV_WDATA[15:8] == 8'h00) else $error("high register overflow");
	a_block_end_addr: assert property (DEV_WR && DEV_SEL == 4'h3
		|-> (($past(DEV_WDATA, 2) & 16'h03FF) == 16'h0000)
		&& DEV_WDATA == ($past(DEV_WDATA, 2) | 16'h03FF)
		##1 DEV_WDATA == $past(DEV_WDATA, 2)) else $error("block range wrong");
	a_no_cmd_busy: assert property (cmd_wr
		|-> busy_hist_ff[9:7] != 3'h7) else $error("command while busy");
endmodule : flash_area_host_properties

bind flash_area_host flash_area_host_properties u_props (.MCLK, .RST,
	.WB_CYC_I, .WB_STB_I, .WB_ACK_O, .DEV_SEL, .DEV_WDATA, .DEV_WR,
	.DEV_CF_BUSY, .DEV_EX_BUSY);

// file: dv/flash_dev_model.sv
// Purpose: Behavioural flash sequencer seen from its register port
// Assumes: Busy rises the cycle after a started command
// Notes:   Fixed busy span; slow enough for the host to see it
`timescale 1ns/100ps
module flash_dev_model #(
	parameter int BUSY_LEN = 12
) (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [3:0]  dev_sel,
	input  wire logic [15:0] dev_wdata,
	input  wire logic        dev_wr,
	output logic             dev_cf_busy
);
	logic [7:0]  area_ff;
	logic [23:0] start_ff;
	logic [23:0] end_ff;
	logic [31:0] wdata_ff;
	logic [7:0]  cmd_ff;
	int          n_cmd_ff;
	int          busy_cnt_ff;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			area_ff  <= 8'h00;
			start_ff <= 24'h00_0000;
			end_ff   <= 24'h00_0000;
			wdata_ff <= 32'h0000_0000;
		end else if (dev_wr) begin
			case (dev_sel)
			4'h0: area_ff <= dev_wdata[7:0];
			4'h1: start_ff[15:0] <= dev_wdata;
			4'h2: start_ff[23:16] <= dev_wdata[7:0];
			4'h3: end_ff[15:0] <= dev_wdata;
			4'h4: end_ff[23:16] <= dev_wdata[7:0];
			4'h5: wdata_ff[15:0] <= dev_wdata;
			4'h6: wdata_ff[31:16] <= dev_wdata;
			default: ;
			endcase
		end
	end

	// Only the code/data area starts; the extra area is not modelled
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cmd_ff      <= 8'h00;
			n_cmd_ff    <= 0;
			busy_cnt_ff <= 0;
		end else if (dev_wr && dev_sel == 4'h7 && dev_wdata[7]
			&& !area_ff[0]) begin
			cmd_ff      <= dev_wdata[7:0];
			n_cmd_ff    <= n_cmd_ff + 1;
			busy_cnt_ff <= BUSY_LEN;
		end else if (busy_cnt_ff != 0) begin
			busy_cnt_ff <= busy_cnt_ff - 1;
		end
	end

	assign dev_cf_busy = busy_cnt_ff != 0;
endmodule : flash_dev_model

// file: dv/flash_area_host_tb_top.sv
// Purpose: Directed register-level tests of the flash host
// Assumes: Classic Wishbone master, 25 MHz clock
// Notes:   START_WAIT shortened to keep the run brief
`timescale 1ns/100ps
`include "flash_seq_regs.svh"
module flash_area_host_tb_top;
	logic        mclk, rst, cyc, stb, we, ack, irq, dev_wr, dev_cf_busy;
	logic        ex_busy, code_mode, data_mode, access_on;
	logic [7:0]  adr;
	logic [31:0] wdat, dat_o, rdat;
	logic [3:0]  dev_sel;
	logic [15:0] dev_wdata;
	int          err_total;
	int          num_checks;

	flash_area_host #(.START_WAIT(8)) dut (.MCLK(mclk), .RST(rst),
		.CE(1'b1), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
		.WB_WE_I(we), .WB_SEL_I(4'hF), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_ACK_O(ack), .IRQ(irq), .DEV_SEL(dev_sel), .DEV_WDATA(dev_wdata),
		.DEV_WR(dev_wr), .DEV_CF_BUSY(dev_cf_busy), .DEV_EX_BUSY(ex_busy),
		.DEV_CODE_MODE(code_mode), .DEV_DATA_MODE(data_mode),
		.DEV_ACCESS_ON(access_on));
	flash_dev_model dev (.mclk, .rst, .dev_sel, .dev_wdata, .dev_wr,
		.dev_cf_busy);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %h vs %h", $time, got, exp);
		end
	endtask : chk

	// Hold the request until ack is sampled, then drop for a cycle
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		if (n >= 50)
			err_total++;
	endtask : wb

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0000_0000);
		chk(rdat, exp);
	endtask : rd_chk

	// Start op on blk, wait for the interrupt, expect ev, then clear it
	task automatic run_cmd(input logic [2:0] op, input logic [9:0] blk,
		input logic [31:0] ev);
		int n;
		n = 0;
		wb(1'b1, `FS_OFS_BLOCK, {22'h00_0000, blk});
		wb(1'b1, `FS_OFS_CTRL, {24'h00_0000, 5'h10, op});
		while (irq !== 1'b1 && n < 400) begin
			@(posedge mclk);
			n++;
		end
		if (n >= 400)
			err_total++;
		rd_chk(`FS_OFS_IRQ_STAT, ev);
		wb(1'b1, `FS_OFS_IRQ_STAT, 32'h0000_0003);
	endtask : run_cmd

	task automatic dev_chk(input logic [23:0] sa, input logic [23:0] ea,
		input logic [7:0] cmd);
		chk({24'h00_0000, dev.area_ff}, 32'h0000_0000);
		chk({8'h00, dev.start_ff}, {8'h00, sa});
		chk({8'h00, dev.end_ff}, {8'h00, ea});
		chk({24'h00_0000, dev.cmd_ff}, {24'h00_0000, cmd});
	endtask : dev_chk

	initial begin
		repeat (20000) @(posedge mclk);
		err_total++;
		tally_and_finish();
	end

	initial begin
		{rst, cyc, stb, we, ex_busy, code_mode, data_mode, access_on} = 8'h80;
		adr = 8'h00;
		wdat = 32'h0000_0000;
		err_total = 0;
		num_checks = 0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		for (int a = 0; a < 32; a += 4)
			rd_chk(8'(a), 32'h0000_0000);
		// Erase outside data mode with the mask still closed
		wb(1'b1, `FS_OFS_CTRL, 32'h0000_0084);
		repeat (12) @(posedge mclk);
		chk({31'h0, irq}, 32'h0000_0000);
		rd_chk(`FS_OFS_IRQ_STAT, 32'h0000_0002);
		wb(1'b1, `FS_OFS_IRQ_MASK, 32'h0000_0003);
		// Mask lands at the ack edge; look once it has settled
		@(posedge mclk);
		chk({31'h0, irq}, 32'h0000_0001);
		wb(1'b1, `FS_OFS_IRQ_STAT, 32'h0000_0003);
		@(posedge mclk);
		chk({31'h0, irq}, 32'h0000_0000);
		code_mode <= 1'b1;
		wb(1'b1, `FS_OFS_PADDR, 32'h0000_1400);
		wb(1'b1, `FS_OFS_PDATA, 32'hA5A5_1234);
		run_cmd(3'h1, 10'h000, 32'h0000_0001);
		chk(dev.wdata_ff, 32'hA5A5_1234);
		rd_chk(`FS_OFS_STATUS, 32'h0000_0012);
		run_cmd(3'h2, 10'h005, 32'h0000_0001);
		dev_chk(24'h00_1400, 24'h00_17FF, 8'h82);
		run_cmd(3'h2, 10'h005, 32'h0000_0002);
		run_cmd(3'h3, 10'h007, 32'h0000_0001);
		dev_chk(24'h00_1C00, 24'h00_1FFF, 8'h83);
		wb(1'b1, `FS_OFS_PADDR, 32'h0000_2400);
		run_cmd(3'h1, 10'h000, 32'h0000_0001);
		code_mode <= 1'b0;
		run_cmd(3'h2, 10'h009, 32'h0000_0002);
		code_mode <= 1'b1;
		ex_busy <= 1'b1;
		run_cmd(3'h2, 10'h009, 32'h0000_0002);
		ex_busy <= 1'b0;
		run_cmd(3'h2, 10'h209, 32'h0000_0002);
		run_cmd(3'h2, 10'h009, 32'h0000_0001);
		dev_chk(24'h00_2400, 24'h00_27FF, 8'h82);
		code_mode <= 1'b0;
		data_mode <= 1'b1;
		run_cmd(3'h4, 10'h003, 32'h0000_0002);
		access_on <= 1'b1;
		run_cmd(3'h4, 10'h040, 32'h0000_0002);
		run_cmd(3'h4, 10'h03F, 32'h0000_0001);
		dev_chk(24'h10_FC00, 24'h10_FFFF, 8'h84);
		chk(32'(dev.n_cmd_ff), 32'h0000_0006);
		tally_and_finish();
	end
endmodule : flash_area_host_tb_top
